// ### rtl/sar_adc_sequencer_map.svh
`ifndef SAR_ADC_SEQUENCER_MAP_SVH
`define SAR_ADC_SEQUENCER_MAP_SVH
// ----------------------------------------
// sizes and reset values
// ----------------------------------------
`define ADC_WIDTH 8
`define ADC_CHANNELS 4
`define ADC_MSB_NIBBLE 4
`define ADC_DIV_MAX 8
`define ADC_RESULT_RESET 8'h00
`define ADC_DIV_RESET 3'h0
`endif

// ### rtl/sar_adc_sequencer_pkg.sv
package sar_adc_sequencer_pkg;
   typedef enum logic [2:0] {
      mode_fixed_single,
      mode_fixed_cont,
      mode_scan_single,
      mode_scan_cont,
      mode_dual_cont,
      mode_single_step
   } adc_mode_t;
   typedef enum logic [1:0] {
      start_timer,
      start_now,
      start_edge,
      start_off
   } start_src_t;
endpackage : sar_adc_sequencer_pkg

// ### rtl/sar_adc_sequencer.sv
`timescale 1ns/1ns
`include "sar_adc_sequencer_map.svh"
module sar_adc_sequencer (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_enable,
   input wire sar_adc_sequencer_pkg::adc_mode_t i_mode,
   input wire sar_adc_sequencer_pkg::start_src_t i_start_src,
   input wire logic [3:0] i_chan_sel,
   input wire logic [2:0] i_clk_div,
   input wire logic i_stop,
   input wire logic i_timer0_ovf,
   input wire logic i_edge_trigger_pin,
   input wire logic i_power_down,
   input wire logic i_irq_en,
   input wire logic i_group_irq_en,
   input wire logic i_bnd_irq_en,
   input wire logic i_bnd_outside,
   input wire logic [7:0] i_bnd_high,
   input wire logic [7:0] i_bnd_low,
   input wire logic i_flag_clr,
   input wire logic i_bnd_status_clr,
   input wire logic i_dac_mode,
   input wire logic i_dac_wr,
   input wire logic [7:0] i_dac_data,
   input wire logic i_comparator,
   output logic [1:0] o_mux_chan,
   output logic o_sample,
   output logic [7:0] o_dac_code,
   output logic o_dac_pin_en,
   output logic [7:0] o_result_reg_0,
   output logic [7:0] o_result_reg_1,
   output logic [7:0] o_result_reg_2,
   output logic [7:0] o_result_reg_3,
   output logic [3:0] o_boundary_status_reg,
   output logic o_done_flag,
   output logic o_bnd_flag,
   output logic o_irq,
   output logic o_busy
);
   import sar_adc_sequencer_pkg::*;

   typedef enum logic [1:0] {st_idle, st_sample, st_convert, st_store} state_t;

   // ----------------------------------------
   // input synchronisers and start detection
   // ----------------------------------------
   logic [1:0] pin_sync;
   logic pin_last;
   logic [1:0] ovf_sync;
   logic ovf_last;
   logic src_now_last;
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         pin_sync <= 2'h0;
         pin_last <= 1'b0;
         ovf_sync <= 2'h0;
         ovf_last <= 1'b0;
         src_now_last <= 1'b0;
      end
      else
      begin
         pin_sync <= {pin_sync[0], i_edge_trigger_pin};
         pin_last <= pin_sync[1];
         ovf_sync <= {ovf_sync[0], i_timer0_ovf};
         ovf_last <= ovf_sync[1];
         src_now_last <= (i_start_src == start_now) && i_enable;
      end
   end

   logic start_req;
   always_comb
   begin
      case (i_start_src)
         start_timer: start_req = ovf_sync[1] && !ovf_last;
         start_now: start_req = !src_now_last;
         start_edge: start_req = pin_sync[1] != pin_last;
         default: start_req = 1'b0;
      endcase
   end

   // ----------------------------------------
   // clock divider
   // ----------------------------------------
   logic [2:0] div_cnt;
   logic tick;
   assign tick = (div_cnt == i_clk_div);
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst || tick)
         div_cnt <= `ADC_DIV_RESET;
      else
         div_cnt <= div_cnt + 3'h1;
   end

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   state_t state;
   logic [1:0] chan;
   logic [1:0] slot;
   logic [3:0] done_mask;
   logic [2:0] bit_idx;
   logic [7:0] approx;
   logic early_hit;
   logic run;
   logic active;
   assign active = i_enable && !i_power_down;
   assign o_busy = (state != st_idle);
   assign o_mux_chan = chan;
   assign o_sample = (state == st_sample);

   // first selected channel above a given one, wrapping
   function automatic logic [1:0] next_sel(input logic [3:0] sel, input logic [1:0] cur);
      logic [1:0] c;
      c = cur;
      for (int k = 0; k < `ADC_CHANNELS; k++)
      begin
         c = c + 2'h1;
         if (sel[c])
            return c;
      end
      return cur;
   endfunction : next_sel

   logic [1:0] first_ch;
   logic [1:0] second_ch;
   assign first_ch = next_sel(i_chan_sel, 2'h3);
   assign second_ch = next_sel(i_chan_sel, first_ch);
   logic last_in_scan;
   assign last_in_scan = ((done_mask | (4'h1 << chan)) & i_chan_sel) == i_chan_sel;
   logic scan_mode;
   assign scan_mode = (i_mode == mode_scan_single) || (i_mode == mode_scan_cont)
      || (i_mode == mode_single_step);
   logic [1:0] dest;
   assign dest = (i_mode == mode_fixed_cont || i_mode == mode_dual_cont) ? slot : chan;

   // completion events for the store cycle
   logic seq_end;
   logic group_end;
   always_comb
   begin
      seq_end = 1'b0;
      group_end = 1'b0;
      case (i_mode)
         mode_fixed_single: seq_end = 1'b1;
         mode_fixed_cont: group_end = (slot == 2'h3) && i_group_irq_en;
         mode_scan_single: seq_end = last_in_scan;
         mode_scan_cont: group_end = last_in_scan;
         mode_dual_cont: group_end = (slot == 2'h3);
         mode_single_step: seq_end = 1'b1;
         default: seq_end = 1'b1;
      endcase
   end

   logic stored;
   assign stored = (state == st_store) && !(i_stop || !active);

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         state <= st_idle;
         chan <= 2'h0;
         slot <= 2'h0;
         done_mask <= 4'h0;
         bit_idx <= 3'h7;
         approx <= 8'h00;
         run <= 1'b0;
      end
      else if (!active || i_stop)
      begin
         state <= st_idle;
         run <= 1'b0;
         done_mask <= 4'h0;
      end
      else
      begin
         case (state)
            st_idle:
               if (start_req && !i_dac_mode && i_chan_sel != 4'h0)
               begin
                  if (!(i_mode == mode_single_step && run))
                  begin
                     chan <= first_ch;
                     slot <= 2'h0;
                     done_mask <= 4'h0;
                  end
                  else
                     chan <= next_sel(i_chan_sel, chan);
                  run <= 1'b1;
                  state <= st_sample;
               end
            st_sample:
               if (tick)
               begin
                  bit_idx <= 3'h7;
                  approx <= 8'h80;
                  state <= st_convert;
               end
            st_convert:
               if (tick)
               begin
                  approx[bit_idx] <= i_comparator;
                  if (bit_idx == 3'h0)
                     state <= st_store;
                  else
                  begin
                     approx[bit_idx - 3'h1] <= 1'b1;
                     bit_idx <= bit_idx - 3'h1;
                  end
               end
            st_store:
            begin
               slot <= slot + 2'h1;
               done_mask <= last_in_scan ? 4'h0 : (done_mask | (4'h1 << chan));
               if (seq_end)
               begin
                  state <= st_idle;
                  run <= (i_mode == mode_single_step) && !last_in_scan;
                  if (i_mode == mode_single_step && last_in_scan)
                     chan <= first_ch;
               end
               else
               begin
                  state <= st_sample;
                  if (i_mode == mode_dual_cont)
                     chan <= (chan == first_ch) ? second_ch : first_ch;
                  else if (scan_mode)
                     chan <= next_sel(i_chan_sel, chan);
               end
            end
            default: state <= st_idle;
         endcase
      end
   end

   // ----------------------------------------
   // result registers and dac
   // ----------------------------------------
   logic [7:0] result [`ADC_CHANNELS];
   generate
      for (genvar g = 0; g < `ADC_CHANNELS; g++)
      begin : g_res
         always_ff @(posedge i_clk)
         begin
            if (i_sys_rst)
               result[g] <= `ADC_RESULT_RESET;
            else if (g == 3 && i_dac_mode && i_dac_wr)
               result[g] <= i_dac_data;
            else if (stored && dest == 2'(g))
               result[g] <= approx;
         end
      end
   endgenerate
   assign o_result_reg_0 = result[0];
   assign o_result_reg_1 = result[1];
   assign o_result_reg_2 = result[2];
   assign o_result_reg_3 = result[3];
   assign o_dac_code = i_dac_mode ? result[3] : approx;
   assign o_dac_pin_en = !(i_dac_mode && active);

   // ----------------------------------------
   // boundary limits
   // ----------------------------------------
   logic nib_ready;
   assign nib_ready = (state == st_convert) && tick && (bit_idx == 3'h4);
   logic [3:0] nib;
   assign nib = {approx[7:5], i_comparator};
   logic nib_out;
   assign nib_out = (nib > i_bnd_high[7:4]) || (nib < i_bnd_low[7:4]);
   logic full_in;
   assign full_in = (approx <= i_bnd_high) && (approx >= i_bnd_low);
   logic bnd_event;
   assign bnd_event = i_bnd_irq_en && !i_dac_mode && (
      (i_bnd_outside && nib_ready && nib_out && !early_hit) ||
      (stored && !early_hit && (i_bnd_outside ? !full_in : full_in)));

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst || state == st_sample)
         early_hit <= 1'b0;
      else if (bnd_event && nib_ready)
         early_hit <= 1'b1;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         o_boundary_status_reg <= 4'h0;
      else if (bnd_event)
         o_boundary_status_reg <= o_boundary_status_reg | (4'h1 << chan);
      else if (i_bnd_status_clr)
         o_boundary_status_reg <= 4'h0;
   end

   // ----------------------------------------
   // flags and interrupt
   // ----------------------------------------
   logic done_event;
   assign done_event = stored && (seq_end || group_end);
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         o_done_flag <= 1'b0;
         o_bnd_flag <= 1'b0;
      end
      else
      begin
         if (done_event)
            o_done_flag <= 1'b1;
         else if (i_flag_clr)
            o_done_flag <= 1'b0;
         if (bnd_event)
            o_bnd_flag <= 1'b1;
         else if (i_flag_clr)
            o_bnd_flag <= 1'b0;
      end
   end
   assign o_irq = (o_done_flag && i_irq_en) || o_bnd_flag;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_stop_idle;
      @(posedge i_clk) disable iff (i_sys_rst) i_stop |=> state == st_idle;
   endproperty
   a_stop_idle: assert property (p_stop_idle) else $error("stop not honoured");

   property p_pd_idle;
      @(posedge i_clk) disable iff (i_sys_rst) i_power_down |=> !o_busy;
   endproperty
   a_pd_idle: assert property (p_pd_idle) else $error("busy in power-down");

   property p_done_sticky;
      @(posedge i_clk) disable iff (i_sys_rst) o_done_flag && !i_flag_clr |=> o_done_flag;
   endproperty
   a_done_sticky: assert property (p_done_sticky) else $error("flag lost");

   property p_set_wins;
      @(posedge i_clk) disable iff (i_sys_rst) done_event && i_flag_clr |=> o_done_flag;
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("clear beat set");

   property p_bnd_off;
      @(posedge i_clk) disable iff (i_sys_rst)
         !i_bnd_irq_en && !o_bnd_flag |=> !o_bnd_flag;
   endproperty
   a_bnd_off: assert property (p_bnd_off) else $error("limit flag while off");

   property p_single_ends;
      @(posedge i_clk) disable iff (i_sys_rst)
         stored && i_mode == mode_fixed_single |=> state == st_idle && o_done_flag;
   endproperty
   a_single_ends: assert property (p_single_ends) else $error("single not ended");

   property p_ignore_busy;
      @(posedge i_clk) disable iff (i_sys_rst)
         state == st_convert && start_req && !i_stop && active |=> state != st_sample;
   endproperty
   a_ignore_busy: assert property (p_ignore_busy) else $error("restart while busy");

   property p_dac_hold;
      @(posedge i_clk) disable iff (i_sys_rst)
         i_dac_mode && i_dac_wr |=> result[3] == $past(i_dac_data);
   endproperty
   a_dac_hold: assert property (p_dac_hold) else $error("dac value lost");

endmodule : sar_adc_sequencer

// ### dv/sar_adc_sequencer_tb.sv
`timescale 1ns/1ns
module sar_adc_sequencer_tb;
   import sar_adc_sequencer_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1, en = 1'b1, stop = 1'b0, tmr = 1'b0, pin = 1'b0, pd = 1'b0;
   logic irq_en = 1'b1, grp_en = 1'b1, bnd_en = 1'b0, bnd_out = 1'b0;
   logic fclr = 1'b0, sclr = 1'b0, dmode = 1'b0, dwr = 1'b0, comp = 1'b0;
   logic [7:0] hi = 8'h00, lo = 8'h00, ddata = 8'h00;
   logic [3:0] sel = 4'h1;
   logic [2:0] div = 3'h0;
   adc_mode_t mode = mode_fixed_single;
   start_src_t src = start_off;
   logic [1:0] mux;
   logic samp, dpin_en, done, bflg, irq, busy;
   logic [7:0] dcode;
   logic [7:0] r [4];
   logic [3:0] bst;
   logic [7:0] vin [4];
   int bad_count = 0;
   int compares = 0;
   int n;

   sar_adc_sequencer u_dut (
      .i_clk(clk), .i_sys_rst(rst), .i_enable(en), .i_mode(mode), .i_start_src(src),
      .i_chan_sel(sel), .i_clk_div(div), .i_stop(stop), .i_timer0_ovf(tmr),
      .i_edge_trigger_pin(pin), .i_power_down(pd), .i_irq_en(irq_en),
      .i_group_irq_en(grp_en), .i_bnd_irq_en(bnd_en), .i_bnd_outside(bnd_out),
      .i_bnd_high(hi), .i_bnd_low(lo), .i_flag_clr(fclr), .i_bnd_status_clr(sclr),
      .i_dac_mode(dmode), .i_dac_wr(dwr), .i_dac_data(ddata), .i_comparator(comp),
      .o_mux_chan(mux), .o_sample(samp), .o_dac_code(dcode), .o_dac_pin_en(dpin_en),
      .o_result_reg_0(r[0]), .o_result_reg_1(r[1]), .o_result_reg_2(r[2]),
      .o_result_reg_3(r[3]), .o_boundary_status_reg(bst), .o_done_flag(done),
      .o_bnd_flag(bflg), .o_irq(irq), .o_busy(busy)
   );

   // ----------------------------------------
   // clock and analog side
   // ----------------------------------------
   always #50 clk = ~clk;

   // comparator high while the input is at or above the trial code
   always @(negedge clk) comp <= (vin[mux] >= dcode);

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
      compares++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic tick(int k);
      repeat (k) @(negedge clk);
   endtask : tick

   task automatic wait_busy(logic lvl);
      int k;
      k = 0;
      while (busy !== lvl && k < 400)
      begin
         tick(1);
         k++;
      end
      check("busy", 8'(busy), 8'(lvl));
   endtask : wait_busy

   task automatic wait_done();
      int k;
      k = 0;
      while (done !== 1'b1 && k < 3000)
      begin
         tick(1);
         k++;
      end
      check("done", 8'(done), 8'h01);
   endtask : wait_done

   task automatic go(adc_mode_t m, start_src_t s, logic [3:0] ch);
      tick(1);
      src = start_off;
      mode = m;
      sel = ch;
      tick(3);
      src = s;
      tick(3);
      if (s == start_timer)
         tmr = 1'b1;
      if (s == start_edge)
         pin = ~pin;
      tick(1);
      tmr = 1'b0;
   endtask : go

   task automatic conv(logic [3:0] ch);
      go(mode_fixed_single, start_now, ch);
      wait_busy(1'b1);
      wait_busy(1'b0);
   endtask : conv

   task automatic halt();
      src = start_off;
      stop = 1'b1;
      tick(3);
      stop = 1'b0;
      tick(1);
   endtask : halt

   task automatic clr();
      fclr = 1'b1;
      sclr = 1'b1;
      tick(1);
      fclr = 1'b0;
      sclr = 1'b0;
      tick(1);
   endtask : clr

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : close_out

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial
   begin
      vin = '{8'h5a, 8'hc3, 8'h3c, 8'ha5};
      tick(12);
      rst = 1'b0;
      tick(1);
      for (int i = 0; i < 4; i++)
         check("reset result", r[i], 8'h00);
      check("reset irq", 8'(irq), 8'h00);
      check("reset pin en", 8'(dpin_en), 8'h01);
      conv(4'b0100);
      check("r2", r[2], 8'h3c);
      check("r0", r[0], 8'h00);
      check("irq", 8'(irq), 8'h01);
      irq_en = 1'b0;
      tick(1);
      check("irq off", 8'(irq), 8'h00);
      clr();
      check("done clr", 8'(done), 8'h00);
      irq_en = 1'b1;
      go(mode_fixed_single, start_timer, 4'b1000);
      wait_busy(1'b1);
      tmr = 1'b1;
      tick(1);
      tmr = 1'b0;
      wait_busy(1'b0);
      tick(10);
      check("timer retrigger", 8'(busy), 8'h00);
      check("r3", r[3], 8'ha5);
      clr();
      vin[3] = 8'h96;
      go(mode_scan_single, start_edge, 4'b1011);
      wait_busy(1'b1);
      pin = ~pin;
      wait_done();
      wait_busy(1'b0);
      tick(10);
      check("edge retrigger", 8'(busy), 8'h00);
      check("scan r0", r[0], 8'h5a);
      check("scan r1", r[1], 8'hc3);
      check("scan r2", r[2], 8'h3c);
      check("scan r3", r[3], 8'h96);
      clr();
      vin[1] = 8'h42;
      go(mode_fixed_cont, start_timer, 4'b0010);
      wait_done();
      for (int i = 0; i < 4; i++)
         check("rotate", r[i], 8'h42);
      check("still running", 8'(busy), 8'h01);
      halt();
      vin[1] = 8'h24;
      tick(40);
      check("stopped", 8'(busy), 8'h00);
      check("no write", r[0], 8'h42);
      grp_en = 1'b0;
      clr();
      go(mode_fixed_cont, start_now, 4'b0010);
      tick(60);
      check("no group flag", 8'(done), 8'h00);
      check("group running", 8'(busy), 8'h01);
      halt();
      grp_en = 1'b1;
      clr();
      vin[1] = 8'h19;
      vin[2] = 8'h2e;
      go(mode_dual_cont, start_now, 4'b0110);
      wait_done();
      halt();
      for (int i = 0; i < 4; i++)
         check("dual", r[i], i[0] ? 8'h2e : 8'h19);
      clr();
      go(mode_scan_cont, start_now, 4'b0101);
      wait_done();
      vin[0] = 8'h77;
      vin[2] = 8'h88;
      for (int i = 0; i < 2; i++)
      begin
         clr();
         wait_done();
      end
      fclr = 1'b1;
      tick(30);
      fclr = 1'b0;
      wait_done();
      halt();
      check("rescan r0", r[0], 8'h77);
      check("rescan r2", r[2], 8'h88);
      clr();
      vin[0] = 8'h0f;
      vin[3] = 8'hf0;
      go(mode_single_step, start_edge, 4'b1001);
      wait_done();
      wait_busy(1'b0);
      tick(10);
      check("step waits", 8'(busy), 8'h00);
      check("step r0", r[0], 8'h0f);
      clr();
      pin = ~pin;
      wait_done();
      wait_busy(1'b0);
      check("step r3", r[3], 8'hf0);
      clr();
      bnd_en = 1'b1;
      lo = 8'h10;
      hi = 8'h20;
      vin[1] = 8'h15;
      conv(4'b0010);
      check("inside", 8'(bflg), 8'h01);
      check("status", 8'(bst), 8'h02);
      clr();
      vin[1] = 8'h30;
      conv(4'b0010);
      check("not inside", 8'(bflg), 8'h00);
      bnd_out = 1'b1;
      go(mode_fixed_single, start_now, 4'b1000);
      wait_busy(1'b1);
      repeat (40)
         if (bflg !== 1'b1 && busy === 1'b1)
            tick(1);
      check("early hit", 8'(busy), 8'h01);
      wait_busy(1'b0);
      check("status3", 8'(bst), 8'h08);
      clr();
      vin[3] = 8'h21;
      conv(4'b1000);
      check("late hit", 8'(bflg), 8'h01);
      clr();
      bnd_en = 1'b0;
      vin[3] = 8'hf0;
      conv(4'b1000);
      check("limit off", 8'(bflg), 8'h00);
      dmode = 1'b1;
      ddata = 8'hb7;
      dwr = 1'b1;
      tick(1);
      dwr = 1'b0;
      tick(2);
      check("dac r3", r[3], 8'hb7);
      check("dac code", dcode, 8'hb7);
      check("dac pin", 8'(dpin_en), 8'h00);
      dmode = 1'b0;
      for (int d = 0; d < 8; d++)
      begin
         div = 3'(d);
         go(mode_fixed_single, start_now, 4'b0001);
         wait_busy(1'b1);
         n = 0;
         while (busy === 1'b1 && n < 200)
         begin
            tick(1);
            n++;
         end
         check("span", 8'(n + 3 >= 8 * (d + 1) + 2 && n + 3 <= 9 * (d + 1) + 1), 8'h01);
         check("div r0", r[0], 8'h0f);
      end
      div = 3'h0;
      vin[0] = 8'h99;
      go(mode_fixed_single, start_now, 4'b0001);
      wait_busy(1'b1);
      tick(3);
      pd = 1'b1;
      src = start_off;
      tick(2);
      check("pd stops", 8'(busy), 8'h00);
      pd = 1'b0;
      tick(20);
      check("pd no write", r[0], 8'h0f);
      src = start_now;
      tick(1);
      check("sample", 8'(samp), 8'h01);
      check("mux", 8'(mux), 8'h00);
      tick(1);
      check("sample end", 8'(samp), 8'h00);
      wait_busy(1'b0);
      check("r0 after pd", r[0], 8'h99);
      close_out();
   end

   initial
   begin
      repeat (40000) @(posedge clk);
      bad_count++;
      close_out();
   end
endmodule : sar_adc_sequencer_tb
